// ---- hdl/rseq_consts.svh ----
`ifndef RSEQ_CONSTS_SVH
`define RSEQ_CONSTS_SVH
// Register offsets (8-bit register address space)
`define RSEQ_OFF_RAIL_ENABLE 8'h16
`define RSEQ_OFF_UV_THRESHOLD 8'h18
`define RSEQ_OFF_SLOTS_B1B2 8'h19
`define RSEQ_OFF_SLOTS_B3R1 8'h1A
// Reset values
`define RSEQ_RST_RAIL_ENABLE 8'h00
`define RSEQ_RST_UV_THRESHOLD 8'h03
// Rail enable bit positions
`define RSEQ_BIT_SWITCH_ONE 6
`define RSEQ_BIT_SWITCH_TWO 5
`define RSEQ_BIT_BUCK_ONE 4
`define RSEQ_BIT_BUCK_TWO 3
`define RSEQ_BIT_BUCK_THREE 2
`define RSEQ_BIT_REG_ONE 1
`define RSEQ_BIT_REG_TWO 0
// Slot field positions: upper and lower nibble
`define RSEQ_SLOT_HI_MSB 7
`define RSEQ_SLOT_HI_LSB 4
`define RSEQ_SLOT_LO_MSB 3
`define RSEQ_SLOT_LO_LSB 0
// Threshold field position
`define RSEQ_UV_MSB 1
`define RSEQ_UV_LSB 0
`endif

// ---- hdl/rseq_pkg.sv ----
package rseq_pkg;
  // Undervoltage lockout threshold codes
  typedef enum logic [1:0] {
    RSEQ_UV_2V73 = 2'h0,
    RSEQ_UV_2V89 = 2'h1,
    RSEQ_UV_3V18 = 2'h2,
    RSEQ_UV_3V30 = 2'h3
  } rseq_uv_t;
  // Decoded meaning of a slot field
  typedef enum logic [1:0] {
    RSEQ_SLOT_NONE = 2'h0,
    RSEQ_SLOT_STROBE = 2'h1,
    RSEQ_SLOT_WITH_SYS = 2'h2
  } rseq_slot_kind_t;
endpackage : rseq_pkg

// ---- hdl/rseq_rail_enable_sequencer_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rseq_consts.svh"

module rseq_rail_enable_sequencer_regs #(
  parameter logic [7:0] SLOTS_B1B2_RESET = 8'h15, // Variant dependent, arbitrary default
  parameter logic [7:0] SLOTS_B3R1_RESET = 8'h5F  // Variant dependent, arbitrary default
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,           // Register write strobe (already unlocked)
  input wire logic [7:0] reg_addr_i,   // Register offset
  input wire logic [7:0] reg_wdata_i,  // Write data
  input wire logic power_request_pin_i, // External power enable pin, asynchronous
  output logic [7:0] reg_rdata_o,      // Registered read data
  output logic switch_one_on_o,
  output logic switch_two_on_o,
  output logic buck_one_on_o,
  output logic buck_two_on_o,
  output logic buck_three_on_o,
  output logic regulator_one_on_o,
  output logic regulator_two_on_o,
  output rseq_pkg::rseq_uv_t undervoltage_lockout_threshold_o,
  output logic [3:0] buck_one_slot_o,
  output logic [3:0] buck_two_slot_o,
  output logic [3:0] buck_three_slot_o,
  output logic [3:0] regulator_one_slot_o,
  output rseq_pkg::rseq_slot_kind_t regulator_one_slot_kind_o, // Decoded slot meaning
  output logic [3:0] regulator_one_strobe_o                    // Strobe number, 0 if none
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] rail_enable_q;
  logic [7:0] undervoltage_threshold_q;
  logic [7:0] sequence_slots_bucks_one_two_q;
  logic [7:0] sequence_slots_buck3_reg1_q;
  logic pin_meta_q; // First synchroniser stage, read only by pin_sync_q
  logic pin_sync_q;
  rseq_pkg::rseq_slot_kind_t reg1_kind_d;
  logic [3:0] reg1_strobe_d;
  // Effective slot bytes; the variant defaults are the flops' reset values
  logic [7:0] slots_b1b2_eff;
  logic [7:0] slots_b3r1_eff;
  assign slots_b1b2_eff = sequence_slots_bucks_one_two_q;
  assign slots_b3r1_eff = sequence_slots_buck3_reg1_q;

  // Decoded reset value of the regulator one slot, so the registered
  // decode agrees with the stored default from the first edge on
  localparam logic [3:0] R1_RESET_CODE = SLOTS_B3R1_RESET[3:0];
  localparam bit R1_RESET_SYS = (R1_RESET_CODE == 4'hF);
  localparam bit R1_RESET_STROBE = (R1_RESET_CODE == 4'hE) ||
    ((R1_RESET_CODE >= 4'h1) && (R1_RESET_CODE <= 4'h7));
  localparam rseq_pkg::rseq_slot_kind_t R1_RESET_KIND = R1_RESET_SYS ?
    rseq_pkg::RSEQ_SLOT_WITH_SYS :
    (R1_RESET_STROBE ? rseq_pkg::RSEQ_SLOT_STROBE : rseq_pkg::RSEQ_SLOT_NONE);
  localparam logic [3:0] R1_RESET_STROBE_NUM = (R1_RESET_SYS || R1_RESET_STROBE) ?
    R1_RESET_CODE : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: the pin is asynchronous to the core clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= power_request_pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; the unlock step is the host's job, done upstream
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rail_enable_q <= `RSEQ_RST_RAIL_ENABLE;
      undervoltage_threshold_q <= `RSEQ_RST_UV_THRESHOLD;
      // Variant defaults are parameters, hence constants here
      sequence_slots_bucks_one_two_q <= SLOTS_B1B2_RESET;
      sequence_slots_buck3_reg1_q <= SLOTS_B3R1_RESET;
    end else if (reg_wr_i) begin
      // Whole bytes stored, reserved bits included
      case (reg_addr_i)
        `RSEQ_OFF_RAIL_ENABLE: begin
          rail_enable_q <= reg_wdata_i;
        end
        `RSEQ_OFF_UV_THRESHOLD: begin
          undervoltage_threshold_q <= reg_wdata_i;
        end
        `RSEQ_OFF_SLOTS_B1B2: begin
          sequence_slots_bucks_one_two_q <= reg_wdata_i;
        end
        `RSEQ_OFF_SLOTS_B3R1: begin
          sequence_slots_buck3_reg1_q <= reg_wdata_i;
        end
        default: begin
          // Unmapped offsets are ignored
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `RSEQ_OFF_RAIL_ENABLE: reg_rdata_o <= rail_enable_q;
        `RSEQ_OFF_UV_THRESHOLD: reg_rdata_o <= undervoltage_threshold_q;
        `RSEQ_OFF_SLOTS_B1B2: reg_rdata_o <= slots_b1b2_eff;
        `RSEQ_OFF_SLOTS_B3R1: reg_rdata_o <= slots_b3r1_eff;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail gating: a 1 turns the rail on; switches and bucks also need the synchronised pin
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      switch_one_on_o <= 1'b0;
      switch_two_on_o <= 1'b0;
      buck_one_on_o <= 1'b0;
      buck_two_on_o <= 1'b0;
      buck_three_on_o <= 1'b0;
      regulator_one_on_o <= 1'b0;
      regulator_two_on_o <= 1'b0;
    end else begin
      switch_one_on_o <= rail_enable_q[`RSEQ_BIT_SWITCH_ONE] & pin_sync_q;
      switch_two_on_o <= rail_enable_q[`RSEQ_BIT_SWITCH_TWO] & pin_sync_q;
      buck_one_on_o <= rail_enable_q[`RSEQ_BIT_BUCK_ONE] & pin_sync_q;
      buck_two_on_o <= rail_enable_q[`RSEQ_BIT_BUCK_TWO] & pin_sync_q;
      buck_three_on_o <= rail_enable_q[`RSEQ_BIT_BUCK_THREE] & pin_sync_q;
      // Regulators ignore the pin
      regulator_one_on_o <= rail_enable_q[`RSEQ_BIT_REG_ONE];
      regulator_two_on_o <= rail_enable_q[`RSEQ_BIT_REG_TWO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot decode for regulator one
  always_comb begin
    reg1_kind_d = rseq_pkg::RSEQ_SLOT_NONE;
    reg1_strobe_d = 4'h0;
    case (slots_b3r1_eff[`RSEQ_SLOT_LO_MSB:`RSEQ_SLOT_LO_LSB])
      4'h0, 4'h8, 4'h9: begin
        reg1_kind_d = rseq_pkg::RSEQ_SLOT_NONE;
      end
      4'hF: begin
        reg1_kind_d = rseq_pkg::RSEQ_SLOT_WITH_SYS;
        reg1_strobe_d = 4'hF;
      end
      4'hE: begin
        reg1_kind_d = rseq_pkg::RSEQ_SLOT_STROBE;
        reg1_strobe_d = 4'hE;
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        reg1_kind_d = rseq_pkg::RSEQ_SLOT_STROBE;
        reg1_strobe_d = slots_b3r1_eff[`RSEQ_SLOT_LO_MSB:`RSEQ_SLOT_LO_LSB];
      end
      default: begin
        // Codes 1010..1101 are undefined; treated as outside sequencer
        reg1_kind_d = rseq_pkg::RSEQ_SLOT_NONE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered configuration outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      undervoltage_lockout_threshold_o <= rseq_pkg::RSEQ_UV_3V30;
      // Outputs mirror the stored defaults so no step shows after reset
      buck_one_slot_o <= SLOTS_B1B2_RESET[`RSEQ_SLOT_HI_MSB:`RSEQ_SLOT_HI_LSB];
      buck_two_slot_o <= SLOTS_B1B2_RESET[`RSEQ_SLOT_LO_MSB:`RSEQ_SLOT_LO_LSB];
      buck_three_slot_o <= SLOTS_B3R1_RESET[`RSEQ_SLOT_HI_MSB:`RSEQ_SLOT_HI_LSB];
      regulator_one_slot_o <= R1_RESET_CODE;
      regulator_one_slot_kind_o <= R1_RESET_KIND;
      regulator_one_strobe_o <= R1_RESET_STROBE_NUM;
    end else begin
      undervoltage_lockout_threshold_o <= rseq_pkg::rseq_uv_t'(
        undervoltage_threshold_q[`RSEQ_UV_MSB:`RSEQ_UV_LSB]);
      buck_one_slot_o <= slots_b1b2_eff[`RSEQ_SLOT_HI_MSB:`RSEQ_SLOT_HI_LSB];
      buck_two_slot_o <= slots_b1b2_eff[`RSEQ_SLOT_LO_MSB:`RSEQ_SLOT_LO_LSB];
      buck_three_slot_o <= slots_b3r1_eff[`RSEQ_SLOT_HI_MSB:`RSEQ_SLOT_HI_LSB];
      regulator_one_slot_o <= slots_b3r1_eff[`RSEQ_SLOT_LO_MSB:`RSEQ_SLOT_LO_LSB];
      regulator_one_slot_kind_o <= reg1_kind_d;
      regulator_one_strobe_o <= reg1_strobe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Write strobe aimed at the rail enable register
  sequence s_enable_write;
    reg_wr_i && (reg_addr_i == `RSEQ_OFF_RAIL_ENABLE);
  endsequence

  a_switch_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    switch_one_on_o |-> $past(pin_sync_q))
    else $error("switch one on without pin");
  a_switch_two_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    switch_two_on_o |-> $past(pin_sync_q))
    else $error("switch two on without pin");
  a_buck_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (buck_one_on_o | buck_two_on_o | buck_three_on_o) |-> $past(pin_sync_q))
    else $error("buck on without pin");
  a_reg_ungated: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    regulator_one_on_o == $past(rail_enable_q[`RSEQ_BIT_REG_ONE]))
    else $error("regulator one not following bit");
  a_enable_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_enable_write |=> rail_enable_q == $past(reg_wdata_i))
    else $error("rail enable write lost");
  a_on_follows: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rail_enable_q[`RSEQ_BIT_REG_TWO] |=> regulator_two_on_o)
    else $error("regulator two not on");
  a_uv_field: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    undervoltage_lockout_threshold_o == $past(undervoltage_threshold_q[1:0]))
    else $error("threshold mismatch");
  a_slot_hi: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    buck_one_slot_o == $past(slots_b1b2_eff[7:4]))
    else $error("buck one slot mismatch");
  a_slot_b3: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    buck_three_slot_o == $past(slots_b3r1_eff[7:4]))
    else $error("buck three slot mismatch");
  a_slot_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    regulator_one_slot_kind_o == rseq_pkg::RSEQ_SLOT_STROBE
    |-> regulator_one_strobe_o inside {[4'h1:4'h7], 4'hE})
    else $error("bad strobe for slot");
  a_slot_sys: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $past(slots_b3r1_eff[3:0]) == 4'hF |-> regulator_one_slot_kind_o ==
    rseq_pkg::RSEQ_SLOT_WITH_SYS)
    else $error("code 15 not with system supply");

endmodule : rseq_rail_enable_sequencer_regs
`default_nettype wire

// ---- verif/rseq_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Host side of the register port: one byte per access
module rseq_host_model (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  // Idle bus at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // Write pulse of one cycle; the unlock happens before any call
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    // Released data shows a changed value so a stale byte cannot pass
    reg_wdata_o <= ~data;
  endtask : write_reg

  // Read data is registered, so it is taken one edge after the address
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk_i);
    reg_addr_o <= addr;
    @(posedge core_clk_i);
    #1 data = reg_rdata_i;
  endtask : read_reg
endmodule : rseq_host_model

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic core_clk_i;
  logic rst_n_i;
  logic power_request_pin_i;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic s1, s2, b1, b2, b3, r1, r2;
  rseq_pkg::rseq_uv_t uv;
  logic [3:0] b1_slot, b2_slot, b3_slot, r1_slot, r1_strobe;
  rseq_pkg::rseq_slot_kind_t r1_kind;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] rd;
  // Slot codes: off, strobe bounds, off codes, undefined, 14, 15
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'hA, 4'hE, 4'hF};
  wire logic [7:0] rails = {1'b0, s1, s2, b1, b2, b3, r1, r2};

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 20 ns
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  rseq_host_model host (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

  rseq_rail_enable_sequencer_regs #(.SLOTS_B1B2_RESET(8'h15), .SLOTS_B3R1_RESET(8'h5F)) DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .power_request_pin_i(power_request_pin_i), .reg_rdata_o(reg_rdata),
    .switch_one_on_o(s1), .switch_two_on_o(s2), .buck_one_on_o(b1), .buck_two_on_o(b2),
    .buck_three_on_o(b3), .regulator_one_on_o(r1), .regulator_two_on_o(r2),
    .undervoltage_lockout_threshold_o(uv), .buck_one_slot_o(b1_slot), .buck_two_slot_o(b2_slot),
    .buck_three_slot_o(b3_slot), .regulator_one_slot_o(r1_slot),
    .regulator_one_slot_kind_o(r1_kind), .regulator_one_strobe_o(r1_strobe));

  ////////////////////////////////////////////////////////////////////////////
  // Compare helpers and expected slot decode
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t output %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rd);
    checks_done++;
    if (rd !== exp) begin
      miscompares++;
      $display("ERROR %0t read %h got %h expected %h", $time, a, rd, exp);
    end
  endtask : chk_reg

  // Kind in the top two bits, strobe number in the low nibble
  function automatic logic [7:0] slot_exp(input logic [3:0] c);
    if (c >= 4'h1 && c <= 4'h7) return {rseq_pkg::RSEQ_SLOT_STROBE, 2'h0, c};
    if (c == 4'hE) return {rseq_pkg::RSEQ_SLOT_STROBE, 2'h0, c};
    if (c == 4'hF) return {rseq_pkg::RSEQ_SLOT_WITH_SYS, 2'h0, c};
    return 8'h00;
  endfunction : slot_exp

  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, far beyond the main sequence
  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    power_request_pin_i = 1'b0;
    repeat (12) @(posedge core_clk_i);
    chk_out(rails, 8'h00);
    chk_out({6'h00, uv}, 8'h03);
    rst_n_i <= 1'b1;
    chk_reg(8'h16, 8'h00);
    chk_reg(8'h18, 8'h03);
    chk_reg(8'h19, 8'h15);
    chk_reg(8'h1A, 8'h5F);
    // Pin low: only the two regulators may follow their bits
    host.write_reg(8'h16, 8'hFF);
    chk_reg(8'h16, 8'hFF);
    chk_out(rails, 8'h03);
    @(posedge core_clk_i);
    power_request_pin_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1 chk_out(rails, 8'h7F);
    // One rail at a time, reserved bit set to show it has no effect
    for (int i = 0; i < 7; i++) begin
      host.write_reg(8'h16, 8'h80 | (8'h01 << i));
      repeat (2) @(posedge core_clk_i);
      #1 chk_out(rails, 8'h01 << i);
    end
    host.write_reg(8'h16, 8'h7F);
    power_request_pin_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1 chk_out(rails, 8'h03);
    // Every threshold code, with reserved bits carried along
    for (int c = 0; c < 4; c++) begin
      host.write_reg(8'h18, 8'hA8 | 8'(c));
      chk_reg(8'h18, 8'hA8 | 8'(c));
      chk_out({6'h00, uv}, 8'(c));
    end
    host.write_reg(8'h19, 8'h37);
    chk_reg(8'h19, 8'h37);
    chk_out({b1_slot, b2_slot}, 8'h37);
    foreach (codes[k]) begin
      host.write_reg(8'h1A, {~codes[k], codes[k]});
      chk_reg(8'h1A, {~codes[k], codes[k]});
      chk_out({b3_slot, r1_slot}, {~codes[k], codes[k]});
      chk_out({r1_kind, 2'h0, r1_strobe}, slot_exp(codes[k]));
    end
    // Unmapped offset: write ignored, reads zero
    host.write_reg(8'h17, 8'hAA);
    chk_reg(8'h17, 8'h00);
    chk_reg(8'h16, 8'h7F);
    wrap_up();
  end
endmodule : tb

`default_nettype wire
